// [hw/acc_ctrl.sv]
// comparator control: input routing, output sync, event flag, axi4-lite registers
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module acc_ctrl (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // axi4-lite write
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [acc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [acc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // analog core and pins, asynchronous
  input wire logic cmp_result,
  input wire logic positive_pin_in,
  input wire logic negative_pin_in,
  // converter and cpu, same clock
  input wire logic converter_enable,
  input wire logic [4:0] channel_select_field,
  input wire logic [1:0] reference_source_field,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  // analog routing controls
  output logic pos_mux_route,
  output logic [4:0] pos_channel,
  output logic pos_channel_ok,
  output logic neg_internal_ref,
  output logic [1:0] ref_divider_sel,
  output logic ref_ok,
  output logic comparator_power_off,
  output logic [2:0] auto_trigger_source_field,
  // timer capture and ports
  output logic capture_input,
  output logic positive_pin_din,
  output logic negative_pin_din,
  output logic positive_pin_buf_en,
  output logic negative_pin_buf_en,
  // interrupts
  output logic cmp_irq_req,
  output logic irq
);
  import acc_pkg::*;

  typedef struct packed {
    logic [7:0] conv_b;
    logic [7:0] cmp_cs;
    logic [7:0] didr;
    logic [STS_W-1:0] sts;
    logic [STS_W-1:0] msk;
    logic cmp_s1;
    logic cmp_s2;
    logic cmp_prev;
    logic ppin_s1;
    logic ppin_s2;
    logic npin_s1;
    logic npin_s2;
    logic aw_rdy;
    logic [4:0] awa;
    logic w_rdy;
    logic [7:0] wd;
    logic wbe;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic mux_route;
    logic [4:0] chan;
    logic chan_ok;
    logic neg_ref;
    logic [1:0] ref_div;
    logic ref_ok;
    logic power_off;
    logic cap_in;
    logic ppin_din;
    logic npin_din;
    logic pbuf_en;
    logic nbuf_en;
    logic cmp_irq;
    logic irq;
  } acc_state_t;

  localparam acc_state_t ST_RST = '{
    conv_b: RST_CONV_B, cmp_cs: RST_CMP_CS, didr: RST_DIDR, msk: RST_MSK,
    aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, pbuf_en: 1'b1, nbuf_en: 1'b1, default: '0
  };

  acc_state_t q;
  acc_state_t d;

  function automatic logic [2:0] dec(input logic [4:0] a);
    if (a == OFF_CONV_B) begin
      return SEL_CONV_B;
    end else if (a == OFF_CMP_CS) begin
      return SEL_CMP_CS;
    end else if (a == OFF_DIDR) begin
      return SEL_DIDR;
    end else if (a == OFF_IRQ_STS) begin
      return SEL_STS;
    end else if (a == OFF_IRQ_MSK) begin
      return SEL_MSK;
    end else begin
      return SEL_NONE;
    end
  endfunction : dec

  function automatic logic edge_hit(input logic [1:0] mode, input logic rise, input logic fall);
    case (mode)
      MODE_TOGGLE: return rise | fall;
      MODE_FALL: return fall;
      MODE_RISE: return rise;
      default: return 1'b0;
    endcase
  endfunction : edge_hit

  logic rise;
  logic fall;
  logic evt;
  logic wr_go;
  logic flag_clr;
  logic [2:0] wsel;
  logic [2:0] rsel;

  always_comb begin
    d = q;
    flag_clr = 1'b0;
    wsel = dec(q.awa);
    rsel = dec(s_axi_araddr);
    // synchronisers; first stage feeds only the second
    d.cmp_s1 = cmp_result;
    d.cmp_s2 = q.cmp_s1;
    d.cmp_prev = q.cmp_s2;
    d.ppin_s1 = positive_pin_in;
    d.ppin_s2 = q.ppin_s1;
    d.npin_s1 = negative_pin_in;
    d.npin_s2 = q.npin_s1;
    rise = q.cmp_s2 & ~q.cmp_prev;
    fall = ~q.cmp_s2 & q.cmp_prev;
    // reserved mode 01 never fires
    evt = edge_hit(q.cmp_cs[B_MODE +: 2], rise, fall);

    // write channels taken independently, in either order
    if (q.aw_rdy && s_axi_awvalid) begin
      d.aw_rdy = 1'b0;
      d.awa = s_axi_awaddr;
    end
    if (q.w_rdy && s_axi_wvalid) begin
      d.w_rdy = 1'b0;
      d.wd = s_axi_wdata[7:0];
      d.wbe = s_axi_wstrb[0];
    end
    wr_go = !q.aw_rdy && !q.w_rdy && !q.bvalid;
    if (wr_go) begin
      d.bvalid = 1'b1;
      d.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (q.wbe) begin
        if (wsel == SEL_CONV_B) begin
          d.conv_b = q.wd & CONV_B_WMASK;
        end else if (wsel == SEL_CMP_CS) begin
          // power-off write taken at any time
          d.cmp_cs = (q.wd & CMP_CS_WMASK) | (q.cmp_cs & ~CMP_CS_WMASK);
          flag_clr = q.wd[B_FLAG];
        end else if (wsel == SEL_DIDR) begin
          d.didr = q.wd;
        end else if (wsel == SEL_MSK) begin
          d.msk = q.wd[STS_W-1:0];
        end
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.aw_rdy = 1'b1;
      d.w_rdy = 1'b1;
    end

    // read: data sampled from current state, status clears on read
    if (q.ar_rdy && s_axi_arvalid) begin
      d.ar_rdy = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 8'h00;
      if (rsel == SEL_CONV_B) begin
        d.rdata = q.conv_b;
      end else if (rsel == SEL_CMP_CS) begin
        d.rdata = {q.cmp_cs[7:6], q.cmp_s2, q.cmp_cs[4:0]};
      end else if (rsel == SEL_DIDR) begin
        d.rdata = q.didr;
      end else if (rsel == SEL_STS) begin
        d.rdata = {6'h00, q.sts};
        d.sts = '0;
      end else if (rsel == SEL_MSK) begin
        d.rdata = {6'h00, q.msk};
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.ar_rdy = 1'b1;
    end

    // event flag: a new event wins over a same-cycle clear
    if (irq_vector_ack) begin
      flag_clr = 1'b1;
    end
    d.cmp_cs[B_FLAG] = evt | (q.cmp_cs[B_FLAG] & ~flag_clr);
    d.cmp_cs[B_OUT] = 1'b0;
    // sticky status after read-clear so a set wins
    d.sts[STS_EVT] = d.sts[STS_EVT] | evt;
    d.sts[STS_TOG] = d.sts[STS_TOG] | rise | fall;
    d.irq = |(d.sts & d.msk);

    // request follows flag and both enables
    d.cmp_irq = q.cmp_cs[B_FLAG] & q.cmp_cs[B_IEN] & global_irq_enable;

    // positive input routing; mux only while converter is off
    d.mux_route = q.conv_b[B_ROUTE] & ~converter_enable;
    d.chan = channel_select_field;
    // codes above 10 select nothing defined
    d.chan_ok = channel_select_field <= CH_MAX;
    // negative input: pin or divided internal reference
    d.neg_ref = q.cmp_cs[B_IREF];
    d.ref_div = q.conv_b[B_DIV +: 2];
    d.ref_ok = q.cmp_cs[B_IREF] & (reference_source_field == REFS_INT);
    d.power_off = q.cmp_cs[B_POFF];
    d.cap_in = q.cmp_cs[B_CAP] & q.cmp_s2;
    // disabled buffers read as zero
    d.ppin_din = q.ppin_s2 & ~q.didr[B_PDIS];
    d.npin_din = q.npin_s2 & ~q.didr[B_NDIS];
    d.pbuf_en = ~q.didr[B_PDIS];
    d.nbuf_en = ~q.didr[B_NDIS];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= ST_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign s_axi_awready = q.aw_rdy;
  assign s_axi_wready = q.w_rdy;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.ar_rdy;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = {24'h000000, q.rdata};
  assign s_axi_rresp = q.rresp;
  assign pos_mux_route = q.mux_route;
  assign pos_channel = q.chan;
  assign pos_channel_ok = q.chan_ok;
  assign neg_internal_ref = q.neg_ref;
  assign ref_divider_sel = q.ref_div;
  assign ref_ok = q.ref_ok;
  assign comparator_power_off = q.power_off;
  assign auto_trigger_source_field = q.conv_b[2:0];
  // buffer enables registered, so they trail the disable bits by one clock
  assign positive_pin_buf_en = q.pbuf_en;
  assign negative_pin_buf_en = q.nbuf_en;
  assign capture_input = q.cap_in;
  assign positive_pin_din = q.ppin_din;
  assign negative_pin_din = q.npin_din;
  assign cmp_irq_req = q.cmp_irq;
  assign irq = q.irq;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_sync_lag: assert property (
    clk_en ##1 clk_en |=> q.cmp_s2 == $past(cmp_result, 2))
    else $error("synchronised output does not follow the raw result");

  chk_rise_event: assert property (
    clk_en && q.cmp_cs[1:0] == MODE_RISE && q.cmp_s2 && !q.cmp_prev |=> q.cmp_cs[B_FLAG])
    else $error("rising edge did not set the event flag");

  chk_fall_reserved: assert property (
    clk_en && q.cmp_cs[1:0] != MODE_TOGGLE && !q.cmp_cs[B_FLAG] && !(q.cmp_cs[1:0] == MODE_FALL && fall)
      && !(q.cmp_cs[1:0] == MODE_RISE && rise) |=> !q.cmp_cs[B_FLAG])
    else $error("event flag set without the chosen edge");

  chk_flag_hold: assert property (
    clk_en && q.cmp_s2 == q.cmp_prev && !flag_clr |=> q.cmp_cs[B_FLAG] == $past(q.cmp_cs[B_FLAG]))
    else $error("event flag changed with no edge and no clear");

  chk_vector_clear: assert property (
    clk_en && irq_vector_ack && !evt |=> !q.cmp_cs[B_FLAG])
    else $error("vector acknowledge did not clear the flag");

  chk_irq_gate: assert property (
    clk_en && !(q.cmp_cs[B_FLAG] && q.cmp_cs[B_IEN] && global_irq_enable) |=> !cmp_irq_req)
    else $error("comparator request without flag and both enables");

  chk_pos_route: assert property (
    clk_en |=> pos_mux_route == ($past(q.conv_b[B_ROUTE]) && !$past(converter_enable)))
    else $error("positive input routing wrong");

  chk_neg_pin: assert property (
    clk_en && !q.cmp_cs[B_IREF] |=> !neg_internal_ref && !ref_ok)
    else $error("internal reference used while deselected");

  chk_pin_zero: assert property (
    clk_en && q.didr[B_PDIS] |=> !positive_pin_din && !positive_pin_buf_en)
    else $error("disabled positive pin still reads");

  chk_capture_off: assert property (
    clk_en && !q.cmp_cs[B_CAP] |=> !capture_input)
    else $error("capture fed while route bit clear");

  chk_power_off: assert property (
    clk_en && wr_go && q.wbe && wsel == SEL_CMP_CS ##1 clk_en
      |=> comparator_power_off == $past(q.wd[B_POFF], 2))
    else $error("power-off write not applied");

  chk_status_sticky: assert property (
    clk_en && evt |=> q.sts[STS_EVT])
    else $error("event did not set the sticky status bit");

  chk_enable_freeze: assert property (
    !clk_en |=> $stable(q))
    else $error("state moved while the clock enable was low");

  cov_toggle_event: cover property (clk_en && q.cmp_cs[1:0] == MODE_TOGGLE && evt);
  cov_irq_request: cover property (cmp_irq_req ##1 irq_vector_ack);
  cov_status_read: cover property (q.ar_rdy && s_axi_arvalid && rsel == SEL_STS && q.sts != '0);
endmodule : acc_ctrl

// [hw/acc_pkg.sv]
// constants and state layout for the comparator control block
// Operation
// - The raw comparator result is high while the chosen positive input is above the chosen negative input.
// - With the mux route bit set and the converter off, the converter mux output feeds the positive input.
// - Otherwise the positive pin is used; channel codes 0 to 10 pick channels 0 to 10, code 3 shared with the current source.
// - With the internal reference bit clear, the negative pin feeds the negative input.
// - With internal reference and source field 11, divider codes 00 to 11 pick 2.56, 1.28, 0.64 and 0.32 V.
// - Writing one to the power-off bit switches the comparator off, accepted at any time.
// - The comparator result is synchronised before it shows as the output status bit, 1 to 2 cycles late.
// - The event flag is set when the synchronised output shows the edge chosen by the event mode.
// - Event mode 00 is any toggle, 10 falling, 11 rising, 01 reserved.
// - The event flag clears when the interrupt vector runs or when software writes one to it.
// - An interrupt is requested only while flag, comparator enable and global enable are all set; the irq output follows status and mask without them.
// - With the capture route bit set the output feeds the timer capture front end, else no link exists.
// - A set pin input disable bit turns off that pin's input buffer and its port bit reads zero.
package acc_pkg;
  localparam int ADDR_W = 5;
  // register byte offsets
  localparam logic [4:0] OFF_CONV_B = 5'h00;
  localparam logic [4:0] OFF_CMP_CS = 5'h04;
  localparam logic [4:0] OFF_DIDR = 5'h08;
  localparam logic [4:0] OFF_IRQ_STS = 5'h0c;
  localparam logic [4:0] OFF_IRQ_MSK = 5'h10;
  // decode results
  localparam logic [2:0] SEL_CONV_B = 3'h0;
  localparam logic [2:0] SEL_CMP_CS = 3'h1;
  localparam logic [2:0] SEL_DIDR = 3'h2;
  localparam logic [2:0] SEL_STS = 3'h3;
  localparam logic [2:0] SEL_MSK = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h7;
  // converter_ctrl_status_b fields
  localparam int B_ROUTE = 6;
  localparam int B_DIV = 4;
  localparam logic [7:0] CONV_B_WMASK = 8'h77;
  // comparator_ctrl_status fields
  localparam int B_POFF = 7;
  localparam int B_IREF = 6;
  localparam int B_OUT = 5;
  localparam int B_FLAG = 4;
  localparam int B_IEN = 3;
  localparam int B_CAP = 2;
  localparam int B_MODE = 0;
  localparam logic [7:0] CMP_CS_WMASK = 8'hcf;
  // digital_input_disable_0 fields
  localparam int B_PDIS = 7;
  localparam int B_NDIS = 6;
  // interrupt status bits
  localparam int STS_W = 2;
  localparam int STS_EVT = 0;
  localparam int STS_TOG = 1;
  // reset values
  localparam logic [7:0] RST_CONV_B = 8'h00;
  localparam logic [7:0] RST_CMP_CS = 8'h00;
  localparam logic [7:0] RST_DIDR = 8'h00;
  localparam logic [1:0] RST_MSK = 2'h0;
  // event modes, channel limit, reference source
  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_RISE = 2'h3;
  localparam logic [4:0] CH_MAX = 5'h0a;
  localparam logic [1:0] REFS_INT = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : acc_pkg

// [tb/acc_analog_model.sv]
// behavioural analog comparator core, pins and converter mux
`timescale 1ns/1ps
module acc_analog_model (
  // routing controls from the block
  input wire logic pos_mux_route,
  input wire logic [4:0] pos_channel,
  input wire logic neg_internal_ref,
  input wire logic [1:0] ref_divider_sel,
  input wire logic ref_ok,
  input wire logic comparator_power_off,
  // pin voltages in millivolts
  input wire logic [11:0] pos_pin_mv,
  input wire logic [11:0] neg_pin_mv,
  // comparator result and pin levels
  output logic cmp_result,
  output logic positive_pin_in,
  output logic negative_pin_in
);
  logic [11:0] pos_mv;
  logic [11:0] neg_mv;
  always_comb begin
    // channel k sits at k times 100 mV
    pos_mv = pos_mux_route ? 12'(pos_channel) * 12'd100 : pos_pin_mv;
    // a reserved source gives a level the positive side never beats
    neg_mv = !neg_internal_ref ? neg_pin_mv : ref_ok ? (12'ha00 >> ref_divider_sel) : 12'hfff;
    // unpowered core sits low, so power-off shows as a falling output
    cmp_result = !comparator_power_off && (pos_mv > neg_mv);
    positive_pin_in = pos_pin_mv > 12'h320;
    negative_pin_in = neg_pin_mv > 12'h320;
  end
endmodule : acc_analog_model

// [tb/acc_ctrl_bench.sv]
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module acc_ctrl_bench;
  import acc_pkg::*;
  logic aclk = 0, aresetn = 0, clk_en = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, cmp_result, pos_pin, neg_pin;
  logic [4:0] awaddr = 0, araddr = 0, chan = 0, pch;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, rdiv, refs = 2'h3;
  logic conv_en = 0, gie = 0, vack = 0, mux_route, ch_ok, iref, ref_ok, poff, cap, pdin, ndin, pbuf, nbuf, cirq, irq;
  logic [2:0] trig;
  logic [11:0] pmv = 12'h0c8, nmv = 12'h1f4;
  logic [7:0] v;
  logic [33:0] exp_r[$];
  logic [33:0] exp_b[$];
  integer error_cnt = 0, num_checks = 0, seed = 82, n;

  always #2.5 aclk = ~aclk;

  acc_ctrl uut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .cmp_result(cmp_result), .positive_pin_in(pos_pin),
    .negative_pin_in(neg_pin), .converter_enable(conv_en), .channel_select_field(chan),
    .reference_source_field(refs), .global_irq_enable(gie), .irq_vector_ack(vack), .pos_mux_route(mux_route),
    .pos_channel(pch), .pos_channel_ok(ch_ok), .neg_internal_ref(iref), .ref_divider_sel(rdiv), .ref_ok(ref_ok),
    .comparator_power_off(poff), .auto_trigger_source_field(trig), .capture_input(cap), .positive_pin_din(pdin),
    .negative_pin_din(ndin), .positive_pin_buf_en(pbuf), .negative_pin_buf_en(nbuf), .cmp_irq_req(cirq), .irq(irq));

  acc_analog_model model (.pos_mux_route(mux_route), .pos_channel(pch), .neg_internal_ref(iref),
    .ref_divider_sel(rdiv), .ref_ok(ref_ok), .comparator_power_off(poff), .pos_pin_mv(pmv), .neg_pin_mv(nmv),
    .cmp_result(cmp_result), .positive_pin_in(pos_pin), .negative_pin_in(neg_pin));

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // one edge of gap keeps bready from being set twice in a time step
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic s, input logic [1:0] r);
    @(posedge aclk);
    exp_b.push_back({32'h0, r});
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= {3'($random(seed)), s};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    exp_r.push_back({r, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && exp_r.size() > 0) check({rresp, rdata}, exp_r.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1 && exp_b.size() > 0) check({32'h0, bresp}, exp_b.pop_front());
  end

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_CONV_B, 8'h00, RESP_OKAY);
    rd(OFF_CMP_CS, 8'h00, RESP_OKAY);
    rd(OFF_DIDR, 8'h00, RESP_OKAY);
    rd(OFF_IRQ_MSK, 8'h00, RESP_OKAY);
    rd(5'h14, 8'h00, RESP_SLVERR);
    wr(5'h14, 8'hff, 1'b1, RESP_SLVERR);
    check({pbuf, nbuf}, 2'h3);
    pmv <= 12'h3e8;
    nmv <= 12'h384;
    for (n = 0; n < 8; n++) begin
      v = 8'($random(seed));
      conv_en <= v[0];
      wr(OFF_CONV_B, v, 1'b1, RESP_OKAY);
      rd(OFF_CONV_B, v & 8'h77, RESP_OKAY);
      check({mux_route, rdiv, trig}, {v[6] & !v[0], v[5:4], v[2:0]});
      wr(OFF_DIDR, v, 1'b1, RESP_OKAY);
      rd(OFF_DIDR, v, RESP_OKAY);
      check({pdin, ndin, pbuf, nbuf}, {~v[7:6], ~v[7:6]});
    end
    wr(OFF_DIDR, 8'h00, 1'b0, RESP_OKAY);
    rd(OFF_DIDR, v, RESP_OKAY);
    conv_en <= 1'b0;
    wr(OFF_CONV_B, 8'h00, 1'b1, RESP_OKAY);
    wr(OFF_DIDR, 8'h00, 1'b1, RESP_OKAY);
    // interrupt enable stays clear while the mode changes
    for (n = 0; n < 4; n++) begin
      pmv <= 12'h0c8;
      repeat (6) @(posedge aclk);
      wr(OFF_CMP_CS, {6'h04, n[1:0]}, 1'b1, RESP_OKAY);
      rd(OFF_CMP_CS, {6'h00, n[1:0]}, RESP_OKAY);
      pmv <= 12'h3e8;
      repeat (6) @(posedge aclk);
      rd(OFF_CMP_CS, {3'h1, n == 0 || n == 3, 2'h0, n[1:0]}, RESP_OKAY);
      wr(OFF_CMP_CS, {6'h04, n[1:0]}, 1'b1, RESP_OKAY);
      pmv <= 12'h0c8;
      repeat (6) @(posedge aclk);
      rd(OFF_CMP_CS, {3'h0, n == 0 || n == 2, 2'h0, n[1:0]}, RESP_OKAY);
    end
    wr(OFF_IRQ_MSK, 8'h01, 1'b1, RESP_OKAY);
    check(irq, 1'b1);
    rd(OFF_IRQ_STS, 8'h03, RESP_OKAY);
    rd(OFF_IRQ_STS, 8'h00, RESP_OKAY);
    check(irq, 1'b0);
    wr(OFF_CMP_CS, 8'h18, 1'b1, RESP_OKAY);
    gie <= 1'b1;
    pmv <= 12'h3e8;
    repeat (6) @(posedge aclk);
    check({cirq, irq}, 2'h3);
    gie <= 1'b0;
    repeat (3) @(posedge aclk);
    check(cirq, 1'b0);
    gie <= 1'b1;
    repeat (3) @(posedge aclk);
    check(cirq, 1'b1);
    vack <= 1'b1;
    @(posedge aclk);
    vack <= 1'b0;
    repeat (3) @(posedge aclk);
    check(cirq, 1'b0);
    rd(OFF_CMP_CS, 8'h28, RESP_OKAY);
    wr(OFF_IRQ_MSK, 8'h00, 1'b1, RESP_OKAY);
    check(irq, 1'b0);
    wr(OFF_CMP_CS, 8'h14, 1'b1, RESP_OKAY);
    repeat (4) @(posedge aclk);
    check(cap, 1'b1);
    pmv <= 12'h0c8;
    repeat (6) @(posedge aclk);
    check(cap, 1'b0);
    wr(OFF_CMP_CS, 8'h00, 1'b1, RESP_OKAY);
    pmv <= 12'h3e8;
    repeat (6) @(posedge aclk);
    check(cap, 1'b0);
    wr(OFF_CMP_CS, 8'h90, 1'b1, RESP_OKAY);
    repeat (6) @(posedge aclk);
    check(poff, 1'b1);
    rd(OFF_CMP_CS, 8'h90, RESP_OKAY);
    for (n = 0; n < 4; n++) begin
      wr(OFF_CMP_CS, 8'h44, 1'b1, RESP_OKAY);
      wr(OFF_CONV_B, {2'h0, n[1:0], 4'h0}, 1'b1, RESP_OKAY);
      repeat (6) @(posedge aclk);
      check({ref_ok, iref, rdiv, cap}, {2'h3, n[1:0], n > 1});
    end
    refs <= 2'h1;
    repeat (3) @(posedge aclk);
    check(ref_ok, 1'b0);
    wr(OFF_CMP_CS, 8'h04, 1'b1, RESP_OKAY);
    repeat (6) @(posedge aclk);
    check(cap, 1'b1);
    wr(OFF_CONV_B, 8'h40, 1'b1, RESP_OKAY);
    chan <= 5'h03;
    repeat (6) @(posedge aclk);
    check({mux_route, cap}, 2'h2);
    conv_en <= 1'b1;
    repeat (6) @(posedge aclk);
    check({mux_route, cap}, 2'h1);
    conv_en <= 1'b0;
    chan <= 5'h0a;
    repeat (6) @(posedge aclk);
    check({pch, ch_ok, cap}, {5'h0a, 2'h3});
    wr(OFF_CONV_B, 8'h00, 1'b1, RESP_OKAY);
    chan <= 5'h0b;
    repeat (3) @(posedge aclk);
    check(ch_ok, 1'b0);
    // frozen clock enable: the output change must wait for it
    clk_en <= 1'b0;
    pmv <= 12'h0c8;
    repeat (6) @(posedge aclk);
    check(cap, 1'b1);
    clk_en <= 1'b1;
    repeat (6) @(posedge aclk);
    check(cap, 1'b0);
    repeat (4) @(posedge aclk);
    check(exp_r.size() + exp_b.size(), 0);
    final_report();
  end
endmodule : acc_ctrl_bench
